// ===== core/modem_pkg.sv
// Constants and types for the packet engine.
// Assumes one 200 MHz clock; slow timing uses a 1 ms tick.
package modem_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_TIMEOUT = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	// Control register bit positions
	localparam int CTL_RESP_EN = 0;
	localparam int CTL_ACCEPT_RESP = 1;
	localparam int CTL_ERR_RESP = 2;
	localparam int CTL_ADDR_CHECK = 3;
	localparam int CTL_HEADERLESS = 4;
	localparam int CTL_TRIG_TIMEOUT = 5;
	localparam int CTL_APPEND_CRLF = 6;
	localparam logic [31:0] CTRL_MASK = 32'h0000007F;
	localparam logic [31:0] CTRL_RESET = 32'h0000000F;
	// Address register fields
	localparam int STATION_LSB = 0;
	localparam int GROUP_LSB = 8;
	localparam int PRESET_LSB = 16;
	localparam int RETRY_LSB = 24;
	localparam logic [31:0] ADDR_MASK = 32'h0FFFFFFF;
	localparam logic [31:0] ADDR_RESET = 32'h03000000;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0064;
	// Timing: the 1 ms tick and the 5 s host byte gap
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned TICK_PERIOD_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned GAP_LIMIT_S = 5;
	localparam logic [12:0] GAP_LIMIT_MS = 13'(GAP_LIMIT_S * 1000);
	localparam int unsigned ACK_WAIT_MS_DEFAULT = 10;
	// Packet limits
	localparam logic [7:0] MAX_MSG = 8'h82;
	localparam logic [9:0] MAX_ADDR = 10'h0FF;
	localparam logic [7:0] BURST_LEN = 8'h1A;
	localparam logic [8:0] BUF_DEPTH = 9'h096;
	localparam logic [7:0] BCAST_ADDR = 8'hFF;
	// Characters and command words
	localparam logic [7:0] CH_LEAD = 8'h40;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [23:0] CMD_TEXT = 24'h545854;
	localparam logic [23:0] CMD_BIN = 24'h54424E;
	localparam logic [23:0] FWD_TAG = 24'h525854;
	localparam logic [7:0] FWD_HDR_LEN = 8'h06;
	// Responses: accepted, packet error, completion, delivery failure
	localparam logic [63:0] RSP_TABLE = 64'h4E31_5030_4E30_5031;
	typedef enum logic [2:0] {
		P_LEAD = 3'b000,
		P_CMD = 3'b001,
		P_DEST = 3'b010,
		P_LEN = 3'b011,
		P_MSG = 3'b100,
		P_LF = 3'b101
	} parse_state_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_WAIT = 2'b10,
		TX_ACK = 2'b11
	} tx_state_t;
endpackage : modem_pkg

// ===== core/tick_divider.sv
// Clock divider giving a one-cycle enable pulse.
// Assumes DIV of at least 1.
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
	parameter int unsigned DIV = 200000
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	output logic tick // One-cycle pulse every DIV cycles
);
	localparam int W = $clog2(DIV + 1);
	logic [W-1:0] cnt;

	// Free-running count, pulse on wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt == W'(DIV - 1)) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + W'(1);
			tick <= 1'b0;
		end
	end
endmodule : tick_divider
`default_nettype wire

// ===== core/radio_packet_engine.sv
// Host packet interpreter and acknowledged radio transfers.
// Assumes host bytes as one-cycle strobes, radio frames as byte streams.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Text: lead, command, 3-digit destination, 0-130 bytes, CR LF.
// R2: Binary adds a 3-digit length 000-130 before the message.
// R3: Bad structure or byte gap over 5 s drops the packet.
// R4: Error answer only if responses and error responses on.
// R5: Accepted answer only with accepted-plus-complete; then packet radioed.
// R6: Good radio packets go to the host.
// R7: Address check on: packet for us is acknowledged by radio.
// R8: Address check off: take all packets, acknowledge none.
// R9: Acknowledgement completes transfer; completion answer if responses on.
// R10: No acknowledgement in time resends the same packet, up to retries.
// R11: Repeats dropped after the first but still acknowledged.
// R12: Retries used up: delivery-failure answer if responses on.
// R13: Host waits for completion before next command.
// R14: Headerless radios raw bytes to the preset destination.
// R15: Headerless trigger: CR LF or inter-byte gap timeout.
// R16: Headerless send also starts above 26 buffered bytes.
// R17: Headerless keeps response and address-check options.
// R18: Headerless receive may append CR LF.
// R19: Headerless buffer: 150 bytes; excess lost.
// R20: Station and group addresses are both ours.
// R21: Each host response is four bytes.
// R22: Address and length: 3 decimal digits; out of range is invalid.
module radio_packet_engine import modem_pkg::*; #(
	parameter int unsigned TICK_DIV = TICK_CYCLES,
	parameter int unsigned ACK_WAIT_MS = ACK_WAIT_MS_DEFAULT
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // Slave ready
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // Always OKAY
	input wire logic host_in_valid, // Host byte strobe
	input wire logic [7:0] host_in_data, // Host byte
	output logic host_out_valid, // Byte to host valid
	output logic [7:0] host_out_data, // Byte to host
	input wire logic host_out_ready, // Host takes byte
	output logic radio_tx_valid, // Radio frame byte valid
	output logic [7:0] radio_tx_data, // Radio frame byte
	output logic radio_tx_last, // Last byte of frame
	output logic radio_tx_ack, // Frame is an acknowledgement
	output logic [7:0] radio_tx_dest, // Frame destination
	output logic [7:0] radio_tx_src, // Our station address
	output logic radio_tx_seq, // Frame sequence bit
	input wire logic radio_tx_ready, // Radio takes byte
	input wire logic radio_rx_valid, // Received byte strobe
	input wire logic [7:0] radio_rx_data, // Received byte
	input wire logic radio_rx_last, // Last byte of frame
	input wire logic radio_rx_ack, // Frame is an acknowledgement
	input wire logic [7:0] radio_rx_dest, // Frame destination
	input wire logic [7:0] radio_rx_src, // Frame source
	input wire logic radio_rx_seq // Frame sequence bit
);
	logic tick;
	logic [31:0] ctrl, addr_cfg;
	logic [15:0] hl_timeout;
	logic ph_wr;
	logic [7:0] ph_addr;
	parse_state_t pstate;
	tx_state_t tx_state;
	logic [9:0] acc;
	logic [1:0] dig_cnt;
	logic [23:0] cmd;
	logic is_bin, push, pkt_done, pkt_err, hl_cr, hl_trig, hl_flush, pkt_ready;
	logic [7:0] push_data, msg_cnt, exp_len, pkt_dest;
	logic [12:0] gap_ms;
	logic [15:0] hl_ms, ack_ms;
	logic [7:0] tx_mem [0:BUF_DEPTH-1];
	logic [7:0] wr_ptr, rd_base, fill, tx_len, tx_idx, tx_dest;
	logic [3:0] tx_try, resp_pend, resp_set, resp_clr;
	logic tx_seq, ack_seen, ack_back, tx_rel, ack_pend, ack_seq, rx_out;
	logic [7:0] ack_dest, rx_idx, rx_len, rx_src, last_src, fwd_idx;
	logic [7:0] rx_mem [0:MAX_MSG-1];
	logic have_last, last_seq;
	logic [1:0] resp_idx, resp_sel, sel_now;
	logic load, resp_go, fwd_end, ack_hit, ack_sent, room;
	logic [7:0] fwd_hdr, fwd_total, fwd_byte;

	wire resp_en = ctrl[CTL_RESP_EN];
	wire headerless = ctrl[CTL_HEADERLESS];
	wire addr_check = ctrl[CTL_ADDR_CHECK];
	wire [7:0] station = addr_cfg[STATION_LSB +: 8];
	wire [7:0] group = addr_cfg[GROUP_LSB +: 8];
	wire [3:0] retry = addr_cfg[RETRY_LSB +: 4];

	// Pointer step, wrapping at the send buffer end
	function automatic logic [7:0] ptr_add(input logic [7:0] p, input logic [7:0] n);
		logic [8:0] s;
		s = {1'b0, p} + {1'b0, n};
		return (s >= BUF_DEPTH) ? 8'(s - BUF_DEPTH) : s[7:0];
	endfunction : ptr_add

	// ASCII digit of a byte, position 0 is hundreds
	function automatic logic [7:0] dec_char(input logic [7:0] v, input logic [7:0] pos);
		logic [7:0] d;
		d = (pos == 8'h00) ? v / 8'h64 : (pos == 8'h01) ? (v / 8'h0A) % 8'h0A : v % 8'h0A;
		return CH_ZERO + d;
	endfunction : dec_char

	tick_divider #(.DIV(TICK_DIV)) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick)
	);

	// Zero-wait slave; word accesses only
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr <= 1'b0;
			ph_addr <= 8'h00;
		end else if (hready) begin
			ph_wr <= hsel & htrans[1] & hwrite;
			ph_addr <= haddr[7:0];
		end
	end

	// Configuration writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RESET;
			addr_cfg <= ADDR_RESET;
			hl_timeout <= TIMEOUT_RESET;
		end else if (ph_wr) begin
			if (ph_addr == REG_CTRL) begin
				ctrl <= hwdata & CTRL_MASK;
			end else if (ph_addr == REG_ADDR) begin
				addr_cfg <= hwdata & ADDR_MASK;
			end else if (ph_addr == REG_TIMEOUT) begin
				hl_timeout <= hwdata[15:0];
			end
		end
	end

	// Read data from the address phase; unmapped reads give zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready & hsel & htrans[1] & !hwrite) begin
			if (haddr[7:0] == REG_CTRL) begin
				hrdata <= ctrl;
			end else if (haddr[7:0] == REG_ADDR) begin
				hrdata <= addr_cfg;
			end else if (haddr[7:0] == REG_TIMEOUT) begin
				hrdata <= {16'h0000, hl_timeout};
			end else if (haddr[7:0] == REG_STATUS) begin
				hrdata <= {12'h000, tx_try, fill, tx_state, ack_pend, rx_out, pkt_ready, pstate};
			end else begin
				hrdata <= 32'h00000000;
			end
		end
	end

	wire [7:0] b = host_in_data;
	wire is_digit = (b >= CH_ZERO) && (b <= CH_NINE);
	wire [9:0] nacc = 10'(acc * 10'h00A + {2'b00, b - CH_ZERO});
	wire pkt_busy = (tx_state != TX_IDLE) | pkt_ready;
	assign room = ({1'b0, fill} + {8'h00, push}) < BUF_DEPTH;

	// Host byte parser; in packet mode bytes during a transfer are ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pstate <= P_LEAD;
			acc <= 10'h000;
			dig_cnt <= 2'h0;
			cmd <= 24'h000000;
			is_bin <= 1'b0;
			msg_cnt <= 8'h00;
			exp_len <= 8'h00;
			pkt_dest <= 8'h00;
			gap_ms <= 13'h0000;
			push <= 1'b0;
			push_data <= 8'h00;
			pkt_done <= 1'b0;
			pkt_err <= 1'b0;
			hl_cr <= 1'b0;
			hl_ms <= 16'h0000;
			hl_trig <= 1'b0;
		end else begin
			push <= 1'b0;
			pkt_done <= 1'b0;
			pkt_err <= 1'b0;
			hl_trig <= 1'b0;
			push_data <= b;
			if (headerless) begin
				pstate <= P_LEAD;
				if (host_in_valid) begin
					push <= room; // R14 R19
					hl_cr <= (b == CH_CR);
					hl_trig <= !ctrl[CTL_TRIG_TIMEOUT] & hl_cr & (b == CH_LF); // R15
					hl_ms <= 16'h0000;
				end else if (tick && hl_ms != 16'hFFFF) begin
					hl_ms <= hl_ms + 16'h0001;
					hl_trig <= ctrl[CTL_TRIG_TIMEOUT] & (hl_ms + 16'h0001 == hl_timeout); // R15
				end
			end else if (host_in_valid && !pkt_busy) begin
				gap_ms <= 13'h0000;
				case (pstate)
					P_LEAD: begin
						if (b == CH_LEAD) begin
							pstate <= P_CMD;
							dig_cnt <= 2'h0;
						end else begin
							pkt_err <= 1'b1; // R3
						end
					end
					P_CMD: begin
						cmd <= {cmd[15:0], b};
						dig_cnt <= dig_cnt + 2'h1;
						acc <= 10'h000;
						if (dig_cnt == 2'h2) begin
							dig_cnt <= 2'h0;
							is_bin <= ({cmd[15:0], b} == CMD_BIN); // R2
							if ({cmd[15:0], b} == CMD_TEXT || {cmd[15:0], b} == CMD_BIN) begin
								pstate <= P_DEST; // R1
							end else begin
								pstate <= P_LEAD;
								pkt_err <= 1'b1; // R3
							end
						end
					end
					P_DEST, P_LEN: begin
						acc <= nacc;
						dig_cnt <= dig_cnt + 2'h1;
						msg_cnt <= 8'h00;
						if (!is_digit) begin
							pstate <= P_LEAD;
							pkt_err <= 1'b1; // R22
						end else if (dig_cnt == 2'h2) begin
							dig_cnt <= 2'h0;
							acc <= 10'h000;
							if (pstate == P_DEST && nacc <= MAX_ADDR) begin
								pkt_dest <= nacc[7:0]; // R20
								pstate <= is_bin ? P_LEN : P_MSG;
							end else if (pstate == P_LEN && nacc <= {2'b00, MAX_MSG}) begin
								exp_len <= nacc[7:0]; // R2
								pstate <= P_MSG;
							end else begin
								pstate <= P_LEAD;
								pkt_err <= 1'b1; // R22
							end
						end
					end
					P_MSG: begin
						if (is_bin ? (msg_cnt == exp_len) : (b == CH_CR)) begin
							pstate <= (b == CH_CR) ? P_LF : P_LEAD;
							pkt_err <= (b != CH_CR); // R2
						end else if (msg_cnt == MAX_MSG) begin
							pstate <= P_LEAD;
							pkt_err <= 1'b1; // R1
						end else begin
							push <= 1'b1;
							msg_cnt <= msg_cnt + 8'h01;
						end
					end
					default: begin
						pstate <= P_LEAD;
						pkt_done <= (b == CH_LF); // R1
						pkt_err <= (b != CH_LF);
					end
				endcase
			end else if (pstate != P_LEAD && tick) begin
				gap_ms <= gap_ms + 13'h0001;
				if (gap_ms + 13'h0001 == GAP_LIMIT_MS) begin
					pstate <= P_LEAD;
					pkt_err <= 1'b1; // R3
				end
			end
		end
	end

	// Send buffer; a packet error drops the stored bytes
	always_ff @(posedge hclk) begin
		if (push) begin
			tx_mem[wr_ptr] <= push_data;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr <= 8'h00;
			rd_base <= 8'h00;
			fill <= 8'h00;
		end else if (pkt_err) begin
			wr_ptr <= rd_base; // R3
			fill <= 8'h00;
		end else begin
			wr_ptr <= push ? ptr_add(wr_ptr, 8'h01) : wr_ptr;
			rd_base <= tx_rel ? ptr_add(rd_base, tx_len) : rd_base;
			fill <= fill + {7'h00, push} - (tx_rel ? tx_len : 8'h00);
		end
	end

	wire start_hl = headerless & (fill != 8'h00) & (hl_flush | fill > BURST_LEN); // R16
	wire start_pkt = !headerless & pkt_ready;
	wire [7:0] hl_len = (fill > BURST_LEN) ? BURST_LEN : fill;
	assign ack_hit = radio_rx_valid & radio_rx_last & radio_rx_ack & (radio_rx_seq == tx_seq)
		& (radio_rx_src == tx_dest);
	assign ack_sent = (tx_state == TX_ACK) & radio_tx_ready;

	// Transfer engine: send, await acknowledgement, retry, answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= TX_IDLE;
			tx_len <= 8'h00;
			tx_idx <= 8'h00;
			tx_dest <= 8'h00;
			tx_try <= 4'h0;
			tx_seq <= 1'b0;
			tx_rel <= 1'b0;
			ack_seen <= 1'b0;
			ack_back <= 1'b0;
			ack_ms <= 16'h0000;
			pkt_ready <= 1'b0;
			hl_flush <= 1'b0;
			resp_set <= 4'h0;
		end else begin
			tx_rel <= 1'b0;
			resp_set <= {1'b0, 1'b0, pkt_err & resp_en & ctrl[CTL_ERR_RESP], 1'b0}; // R4
			if (pkt_done) begin
				pkt_ready <= 1'b1;
				resp_set[0] <= resp_en & ctrl[CTL_ACCEPT_RESP]; // R5 R21
			end
			if (hl_trig) begin
				hl_flush <= 1'b1; // R15
			end
			if (tick) begin
				ack_ms <= ack_ms + 16'h0001;
			end
			case (tx_state)
				TX_IDLE: begin
					if (ack_pend) begin
						tx_state <= TX_ACK;
						ack_back <= 1'b0;
					end else if (start_pkt || start_hl) begin
						tx_state <= TX_SEND;
						tx_len <= headerless ? hl_len : fill;
						tx_dest <= headerless ? addr_cfg[PRESET_LSB +: 8] : pkt_dest; // R14
						tx_seq <= ~tx_seq;
						tx_try <= 4'h0;
						tx_idx <= 8'h00;
						ack_seen <= 1'b0;
						pkt_ready <= 1'b0;
						hl_flush <= hl_trig | (hl_flush & (fill > BURST_LEN));
						resp_set[0] <= headerless & resp_en & ctrl[CTL_ACCEPT_RESP]; // R17
					end
				end
				TX_SEND: begin
					if (radio_tx_ready) begin
						tx_idx <= tx_idx + 8'h01;
						if (tx_idx == tx_len) begin
							tx_state <= TX_WAIT;
							ack_ms <= 16'h0000;
						end
					end
				end
				TX_WAIT: begin
					if (ack_pend) begin
						tx_state <= TX_ACK;
						ack_back <= 1'b1;
					end else if (ack_seen) begin
						tx_state <= TX_IDLE;
						tx_rel <= 1'b1;
						resp_set[2] <= resp_en; // R9
					end else if (tick && ack_ms + 16'h0001 >= 16'(ACK_WAIT_MS)) begin
						if (tx_try < retry) begin
							tx_state <= TX_SEND; // R10
							tx_try <= tx_try + 4'h1;
							tx_idx <= 8'h00;
						end else begin
							tx_state <= TX_IDLE;
							tx_rel <= 1'b1;
							resp_set[3] <= resp_en; // R12
						end
					end
				end
				default: begin
					if (radio_tx_ready) begin
						tx_state <= ack_back ? TX_WAIT : TX_IDLE;
					end
				end
			endcase
			if (ack_hit && tx_state != TX_IDLE) begin
				ack_seen <= 1'b1; // R9
			end
		end
	end

	// Radio transmit; first byte is the message length
	assign radio_tx_valid = (tx_state == TX_SEND) | (tx_state == TX_ACK);
	assign radio_tx_ack = (tx_state == TX_ACK);
	assign radio_tx_last = radio_tx_ack | (tx_idx == tx_len);
	assign radio_tx_dest = radio_tx_ack ? ack_dest : tx_dest;
	assign radio_tx_seq = radio_tx_ack ? ack_seq : tx_seq;
	assign radio_tx_src = station;
	assign radio_tx_data = radio_tx_ack ? 8'h00 : (tx_idx == 8'h00) ? tx_len
		: tx_mem[ptr_add(rd_base, tx_idx - 8'h01)];

	wire for_us = (radio_rx_dest == station) | (radio_rx_dest == group); // R20
	wire take = !addr_check | for_us | (radio_rx_dest == BCAST_ADDR); // R8
	wire dup = have_last & (radio_rx_src == last_src) & (radio_rx_seq == last_seq);
	wire rx_ok = (rx_idx == 8'h00) ? (radio_rx_data == 8'h00) : (rx_idx == rx_len);
	wire rx_end = radio_rx_valid & radio_rx_last & !radio_rx_ack & !rx_out;

	// Radio receive; frames during forwarding are dropped
	always_ff @(posedge hclk) begin
		if (radio_rx_valid && !radio_rx_ack && !rx_out && rx_idx != 8'h00 && rx_idx <= MAX_MSG) begin
			rx_mem[rx_idx - 8'h01] <= radio_rx_data;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_idx <= 8'h00;
			rx_len <= 8'h00;
			rx_src <= 8'h00;
			rx_out <= 1'b0;
			have_last <= 1'b0;
			last_src <= 8'h00;
			last_seq <= 1'b0;
			ack_pend <= 1'b0;
			ack_dest <= 8'h00;
			ack_seq <= 1'b0;
		end else begin
			if (fwd_end) begin
				rx_out <= 1'b0;
			end
			if (ack_sent) begin
				ack_pend <= 1'b0;
			end
			if (radio_rx_valid && !radio_rx_ack && !rx_out) begin
				rx_idx <= radio_rx_last ? 8'h00 : rx_idx + 8'h01;
				if (rx_idx == 8'h00) begin
					rx_len <= (radio_rx_data > MAX_MSG) ? 8'hFF : radio_rx_data;
				end
			end
			if (rx_end && rx_ok && take) begin
				if (addr_check && for_us) begin
					ack_pend <= 1'b1; // R7 R11
					ack_dest <= radio_rx_src;
					ack_seq <= radio_rx_seq;
				end
				if (!dup) begin
					rx_out <= 1'b1; // R6 R11
					rx_src <= radio_rx_src;
					have_last <= 1'b1;
					last_src <= radio_rx_src;
					last_seq <= radio_rx_seq;
				end
			end
		end
	end

	// Response flags; a set wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_pend <= 4'h0;
		end else begin
			resp_pend <= (resp_pend & ~resp_clr) | resp_set;
		end
	end

	// Host output: a started response or forward finishes first
	assign load = !host_out_valid | host_out_ready;
	assign resp_go = (resp_idx != 2'h0) | ((fwd_idx == 8'h00) & (|resp_pend));
	assign sel_now = (resp_idx != 2'h0) ? resp_sel : resp_pend[0] ? 2'h0 : resp_pend[1] ? 2'h1
		: resp_pend[2] ? 2'h2 : 2'h3;
	assign resp_clr = (load && resp_go && resp_idx == 2'h3) ? 4'(4'h1 << sel_now) : 4'h0;
	assign fwd_hdr = headerless ? 8'h00 : FWD_HDR_LEN;
	assign fwd_total = fwd_hdr + rx_len + ((!headerless | ctrl[CTL_APPEND_CRLF]) ? 8'h02 : 8'h00); // R18
	assign fwd_end = load & !resp_go & rx_out & (fwd_idx == fwd_total - 8'h01);
	always_comb begin
		if (fwd_idx < 8'h03 && fwd_hdr != 8'h00) begin
			fwd_byte = FWD_TAG[8 * (2 - fwd_idx[1:0]) +: 8];
		end else if (fwd_idx < fwd_hdr) begin
			fwd_byte = dec_char(rx_src, fwd_idx - 8'h03);
		end else if (fwd_idx < fwd_hdr + rx_len) begin
			fwd_byte = rx_mem[fwd_idx - fwd_hdr];
		end else begin
			fwd_byte = (fwd_idx == fwd_hdr + rx_len) ? CH_CR : CH_LF;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			host_out_valid <= 1'b0;
			host_out_data <= 8'h00;
			resp_idx <= 2'h0;
			resp_sel <= 2'h0;
			fwd_idx <= 8'h00;
		end else if (load) begin
			host_out_valid <= resp_go | rx_out;
			if (resp_go) begin
				resp_sel <= sel_now;
				resp_idx <= resp_idx + 2'h1; // R21
				host_out_data <= (resp_idx == 2'h2) ? CH_CR : (resp_idx == 2'h3) ? CH_LF
					: RSP_TABLE[{sel_now, ~resp_idx[0], 3'b000} +: 8];
			end else if (rx_out) begin
				host_out_data <= fwd_byte; // R6
				fwd_idx <= fwd_end ? 8'h00 : fwd_idx + 8'h01;
			end
		end
	end
endmodule : radio_packet_engine
`default_nettype wire

// ===== tb/radio_packet_engine_chk.sv
// Port checker for the packet engine.
// Bound to each engine; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module radio_packet_engine_chk import modem_pkg::*; (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // kind
	input wire logic hwrite, // write
	input wire logic hready, // ready
	input wire logic hreadyout, // ready out
	input wire logic [31:0] hrdata, // read data
	input wire logic host_out_valid, // host valid
	input wire logic [7:0] host_out_data, // host byte
	input wire logic host_out_ready, // host ready
	input wire logic radio_tx_valid, // tx valid
	input wire logic [7:0] radio_tx_data, // tx byte
	input wire logic radio_tx_last, // tx last
	input wire logic radio_tx_ack, // tx ack
	input wire logic radio_tx_seq, // tx seq
	input wire logic radio_tx_ready // tx ready
);
	// One clock domain for all checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read taken in an address phase
	wire logic rd_req = hsel && hready && htrans[1] && !hwrite;
	a_ready_high: assert property (hreadyout) else $error("slave stalled");
	a_host_hold: assert property (host_out_valid && !host_out_ready
		|=> host_out_valid && $stable(host_out_data)) else $error("host byte lost");
	a_tx_hold: assert property (radio_tx_valid && !radio_tx_ready
		|=> radio_tx_valid && $stable({radio_tx_data, radio_tx_last})) else $error("tx byte lost");
	a_ack_single: assert property (radio_tx_valid && radio_tx_ack
		|-> radio_tx_last && radio_tx_data == 8'h00) else $error("bad ack frame");
	a_frame_whole: assert property (radio_tx_valid && radio_tx_ready && !radio_tx_last
		|=> radio_tx_valid && $stable(radio_tx_seq)) else $error("frame cut short");
	a_len_max: assert property ($rose(radio_tx_valid) && !radio_tx_ack
		|-> radio_tx_data <= MAX_MSG) else $error("frame too long");
	a_unmapped_zero: assert property (rd_req && haddr[7:0] == 8'h10
		|=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_status_top: assert property (rd_req && haddr[7:0] == REG_STATUS
		|=> hrdata[31:20] == 12'h000) else $error("status top bits set");
	// Main traffic seen
	c_ack: cover property (radio_tx_valid && radio_tx_ack && radio_tx_ready);
	c_stall: cover property (radio_tx_valid && !radio_tx_ready);
	c_host: cover property (host_out_valid && host_out_ready);
endmodule : radio_packet_engine_chk
bind radio_packet_engine radio_packet_engine_chk u_chk (.*);
`default_nettype wire

// ===== tb/radio_peer_model.sv
// Peer modem on the radio side.
// Assumes the bench fills rxq and sets ack_on.
`timescale 1ns/10ps
`default_nettype none
module radio_peer_model (
	input wire logic hclk, // clock
	input wire logic radio_tx_valid, // byte valid
	input wire logic [7:0] radio_tx_data, // byte
	input wire logic radio_tx_last, // frame end
	input wire logic radio_tx_ack, // ack frame
	input wire logic [7:0] radio_tx_dest, // our address
	input wire logic [7:0] radio_tx_src, // sender
	input wire logic radio_tx_seq, // seq bit
	output logic radio_tx_ready, // byte taken
	output logic radio_rx_valid, // rx strobe
	output logic [7:0] radio_rx_data, // rx byte
	output logic radio_rx_last, // rx last
	output logic radio_rx_ack, // rx ack
	output logic [7:0] radio_rx_dest, // rx dest
	output logic [7:0] radio_rx_src, // rx src
	output logic radio_rx_seq, // rx seq
	input wire logic ack_on // acknowledge frames
);
	logic [26:0] rxq[$]; // Byte, last, ack, dest, src, seq
	logic [7:0] got[$]; // Data frame bytes taken
	int acks = 0; // Ack frames taken
	initial begin
		radio_tx_ready = 1'b0;
		{radio_rx_valid, radio_rx_data, radio_rx_last, radio_rx_ack} = '0;
		{radio_rx_dest, radio_rx_src, radio_rx_seq} = '0;
	end
	// Random stalls; idle data flips so stale bytes look wrong
	always @(posedge hclk) begin
		radio_tx_ready <= 1'($urandom % 2);
		if (radio_tx_valid && radio_tx_ready && radio_tx_ack)
			acks++;
		else if (radio_tx_valid && radio_tx_ready) begin
			got.push_back(radio_tx_data);
			if (radio_tx_last && ack_on)
				rxq.push_back({8'h00, 2'b11, radio_tx_src, radio_tx_dest, radio_tx_seq});
		end
		if (!radio_rx_valid && rxq.size() > 0) begin
			{radio_rx_data, radio_rx_last, radio_rx_ack, radio_rx_dest, radio_rx_src,
				radio_rx_seq} <= rxq.pop_front();
			radio_rx_valid <= 1'b1;
		end else begin
			radio_rx_valid <= 1'b0;
			radio_rx_data <= ~radio_rx_data;
		end
	end
endmodule : radio_peer_model
`default_nettype wire

// ===== tb/radio_packet_engine_bench.sv
// Bench: host packets in, replies and radio frames checked.
// Assumes the engine is the sole AHB slave.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module radio_packet_engine_bench import modem_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, host_in_valid, host_out_ready, ack_on;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [2:0] hsize;
	logic [1:0] htrans;
	logic [7:0] host_in_data, host_out_data, radio_tx_data, radio_tx_dest, radio_tx_src;
	logic [7:0] radio_rx_data, radio_rx_dest, radio_rx_src;
	logic hreadyout, hresp, host_out_valid, radio_tx_valid, radio_tx_last, radio_tx_ack;
	logic radio_tx_seq, radio_tx_ready, radio_rx_valid, radio_rx_last, radio_rx_ack, radio_rx_seq;
	wire logic hready = hreadyout;
	logic [7:0] got_h[$];
	int err_total = 0, checked = 0, cyc = 0, retry;
	string bad[3] = '{"@TXT256", "@TBN001131", "@TQT"};
	radio_packet_engine #(.TICK_DIV(20), .ACK_WAIT_MS(10)) u_dut (.*);
	radio_peer_model u_peer (.*);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Host takes replies with random stalls; ceiling ends a hang
	always @(posedge hclk) begin
		host_out_ready <= 1'($urandom % 2);
		if (host_out_valid && host_out_ready)
			got_h.push_back(host_out_data);
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			test_done();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h000000, a};
		do @(posedge hclk); while (!hready);
		{htrans, hwdata} <= {2'b00, d};
		do @(posedge hclk); while (!hready);
		rd = hrdata;
	endtask : bus
	task automatic send(input string s);
		foreach (s[i]) begin
			{host_in_valid, host_in_data} <= {1'b1, 8'(s[i])};
			@(posedge hclk);
			host_in_valid <= 1'b0;
			@(posedge hclk);
		end
	endtask : send
	task automatic want(input string e, input int n, input logic radio);
		logic [7:0] v;
		string f;
		f = radio ? {" ", e} : e;
		while ((radio ? u_peer.got.size() : got_h.size()) < n * f.len())
			@(posedge hclk);
		repeat (n) foreach (f[i]) begin
			v = radio ? u_peer.got.pop_front() : got_h.pop_front();
			`CHK(v, (radio && i == 0) ? 8'(e.len()) : 8'(f[i]))
		end
	endtask : want
	task automatic frame(input string m, input logic [7:0] src);
		u_peer.rxq.push_back({8'(m.len()), 10'h000, src, 1'b1});
		foreach (m[i])
			u_peer.rxq.push_back({8'(m[i]), 1'(i == m.len() - 1), 9'h000, src, 1'b1});
	endtask : frame
	task test_done();
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// Reset, register defaults, traffic both ways
	initial begin
		void'($urandom(6321));
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, host_in_valid, host_in_data} = '0;
		{hsize, ack_on} = {3'h2, 1'b1};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0);
			`CHK(rd, i == 0 ? CTRL_RESET : i == 1 ? ADDR_RESET : i == 2 ? 32'h64 : 32'h0)
		end
		bus(1'b1, REG_CTRL, 32'h07);
		send("@TXT001HI\r\n");
		want("P1\r\nP0\r\n", 1, 1'b0);
		want("HI", 1, 1'b1);
		foreach (bad[i]) begin
			send(bad[i]);
			want("N0\r\n", 1, 1'b0);
		end
		retry = $urandom % 4;
		ack_on <= 1'b0;
		bus(1'b1, REG_ADDR, 32'(retry) << 24);
		send("@TBN002003ABC\r\n");
		want("P1\r\nN1\r\n", 1, 1'b0);
		want("ABC", retry + 1, 1'b1);
		bus(1'b1, REG_CTRL, 32'h0F);
		frame("OK", 8'h05);
		want("RXT005OK\r\n", 1, 1'b0);
		frame("OK", 8'h05);
		while (u_peer.acks < 2)
			@(posedge hclk);
		repeat (50) @(posedge hclk);
		`CHK(got_h.size(), 0)
		`CHK(u_peer.acks, 2)
		test_done();
	end
endmodule : radio_packet_engine_bench
`default_nettype wire
